// ==== design/pwm_pkg.sv ====
// Package with constants shared by the PWM timer pair.
package pwm_pkg;

   localparam logic [1:0] MODE_PWM     = 2'h3;
   localparam logic [1:0] PERIOD_N6    = 2'h1;
   localparam logic [1:0] PERIOD_N7    = 2'h2;
   localparam logic [1:0] PERIOD_N8    = 2'h3;
   localparam logic [7:0] TOP_N6       = 8'h3F;
   localparam logic [7:0] TOP_N7       = 8'h7F;
   localparam logic [7:0] TOP_N8       = 8'hFF;

   localparam logic [1:0] LOW_CLK_EXT  = 2'h0;
   localparam logic [1:0] LOW_CLK_T1   = 2'h1;
   localparam logic [1:0] LOW_CLK_T4   = 2'h2;
   localparam logic [1:0] LOW_CLK_T16  = 2'h3;

   localparam logic [1:0] HIGH_CLK_LOW = 2'h0;
   localparam logic [1:0] HIGH_CLK_T1  = 2'h1;
   localparam logic [1:0] HIGH_CLK_T16 = 2'h2;
   localparam logic [1:0] HIGH_CLK_T256 = 2'h3;

   localparam logic [1:0] FF_OP_INVERT = 2'h0;
   localparam logic [1:0] FF_OP_SET    = 2'h1;
   localparam logic [1:0] FF_OP_CLEAR  = 2'h2;

   localparam int         PRESCALE_W   = 12;
   localparam int         TAP_T1       = 1;
   localparam int         TAP_T4       = 3;
   localparam int         TAP_T16      = 5;
   localparam int         TAP_T256     = 9;

   localparam logic [7:0] CNT_RESET    = 8'h00;
   localparam logic [7:0] DUTY_RESET   = 8'h00;
   localparam logic [7:0] CONST_RESET  = 8'h00;

endpackage

// ==== design/tick_if.sv ====
// Interface carrying the prescaler tap ticks to the timer pair.
`timescale 1ns/1ps
interface tick_if;
   logic t1;
   logic t4;
   logic t16;
   logic t256;
   modport src (output t1, output t4, output t16, output t256);
   modport dst (input t1, input t4, input t16, input t256);
endinterface

// ==== design/tap_prescaler.sv ====
// Free-running prescaler producing one-cycle tap ticks.
`timescale 1ns/1ps
module tap_prescaler (
   input  wire logic clock,
   input  wire logic reset_n,
   tick_if.src       taps
);
   typedef struct packed {
      logic [pwm_pkg::PRESCALE_W-1:0] cnt;
      logic                           t1;
      logic                           t4;
      logic                           t16;
      logic                           t256;
   } pre_state_t;

   pre_state_t st_r;
   pre_state_t st_nxt;

   function automatic logic tap_hit(input logic [pwm_pkg::PRESCALE_W-1:0] c, input int b);
      logic [pwm_pkg::PRESCALE_W-1:0] m;
      m = '0;
      for (int i = 0; i < pwm_pkg::PRESCALE_W; i++) begin
         m[i] = (i <= b);
      end
      return (c & m) == m;
   endfunction

   // The fastest tap ticks every fourth clock, which keeps it below half the clock.
   always_comb begin
      st_nxt      = st_r;
      st_nxt.cnt  = st_r.cnt + 1'b1;
      st_nxt.t1   = tap_hit(st_r.cnt, pwm_pkg::TAP_T1);
      st_nxt.t4   = tap_hit(st_r.cnt, pwm_pkg::TAP_T4);
      st_nxt.t16  = tap_hit(st_r.cnt, pwm_pkg::TAP_T16);
      st_nxt.t256 = tap_hit(st_r.cnt, pwm_pkg::TAP_T256);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign taps.t1   = st_r.t1;
   assign taps.t4   = st_r.t4;
   assign taps.t16  = st_r.t16;
   assign taps.t256 = st_r.t256;
endmodule // tap_prescaler

// ==== design/timer_pair_pwm.sv ====
// Paired 8-bit timer: low timer PWM generator and high timer interval counter.
`timescale 1ns/1ps
module timer_pair_pwm (
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       low_run,
   input  wire logic       high_run,
   input  wire logic [1:0] pair_mode_field,
   input  wire logic [1:0] period_select,
   input  wire logic [1:0] low_clock_select,
   input  wire logic [1:0] high_clock_select,
   input  wire logic       ext_clock_pin,
   input  wire logic       double_buffer_en,
   input  wire logic       duty_write,
   input  wire logic [7:0] duty_write_data,
   input  wire logic       high_const_write,
   input  wire logic [7:0] high_const_write_data,
   input  wire logic       ff_write,
   input  wire logic [1:0] ff_op,
   input  wire logic       toggle_en,
   input  wire logic       pin_route_timer,
   input  wire logic       shared_port_bit,
   output logic            pwm_output_pin,
   output logic            output_flip_flop,
   output logic [7:0]      low_count,
   output logic [7:0]      high_count,
   output logic [7:0]      duty_active,
   output logic            high_match
);
   typedef struct packed {
      logic [7:0] low_cnt;
      logic [7:0] high_cnt;
      logic [7:0] duty_buf;
      logic [7:0] duty_act;
      logic [7:0] high_const;
      logic       ff;
      logic       ext_s1;
      logic       ext_s2;
      logic       ext_s3;
      logic       pin;
      logic       high_match;
   } pair_state_t;

   pair_state_t st_r;
   pair_state_t st_nxt;
   tick_if      taps ();

   tap_prescaler u_prescaler (
      .clock   (clock),
      .reset_n (reset_n),
      .taps    (taps)
   );

   function automatic logic [7:0] overflow_value(input logic [1:0] sel);
      case (sel)
         pwm_pkg::PERIOD_N6: overflow_value = pwm_pkg::TOP_N6;
         pwm_pkg::PERIOD_N7: overflow_value = pwm_pkg::TOP_N7;
         pwm_pkg::PERIOD_N8: overflow_value = pwm_pkg::TOP_N8;
         default:            overflow_value = pwm_pkg::TOP_N8;
      endcase
   endfunction

   logic       pwm_mode;
   logic       ext_rise;
   logic       low_tick;
   logic       high_tick;
   logic [7:0] low_inc;
   logic [7:0] high_inc;
   logic       low_ovf;
   logic       low_match;

   always_comb begin
      pwm_mode = (pair_mode_field == pwm_pkg::MODE_PWM);
      ext_rise = st_r.ext_s2 & ~st_r.ext_s3;
      case (low_clock_select)
         pwm_pkg::LOW_CLK_EXT: low_tick = ext_rise;
         pwm_pkg::LOW_CLK_T1:  low_tick = taps.t1;
         pwm_pkg::LOW_CLK_T4:  low_tick = taps.t4;
         default:              low_tick = taps.t16;
      endcase
      // The low match pulse is never offered to the high timer in PWM mode.
      case (high_clock_select)
         pwm_pkg::HIGH_CLK_LOW: high_tick = 1'b0;
         pwm_pkg::HIGH_CLK_T1:  high_tick = taps.t1;
         pwm_pkg::HIGH_CLK_T16: high_tick = taps.t16;
         default:               high_tick = taps.t256;
      endcase
      low_inc   = st_r.low_cnt + 8'h01;
      high_inc  = st_r.high_cnt + 8'h01;
      low_ovf   = pwm_mode && low_run && low_tick && (low_inc == overflow_value(period_select));
      low_match = pwm_mode && low_run && low_tick && !low_ovf && (low_inc == st_r.duty_act);
   end

   always_comb begin
      st_nxt            = st_r;
      st_nxt.ext_s1     = ext_clock_pin;
      st_nxt.ext_s2     = st_r.ext_s1;
      st_nxt.ext_s3     = st_r.ext_s2;
      st_nxt.high_match = 1'b0;

      // Stopping the low timer clears its counter so a restart begins at zero.
      if (!low_run || !pwm_mode) begin
         st_nxt.low_cnt = pwm_pkg::CNT_RESET;
      end else if (low_ovf) begin
         st_nxt.low_cnt = pwm_pkg::CNT_RESET;
      end else if (low_tick) begin
         st_nxt.low_cnt = low_inc;
      end

      // Without double buffering the write reaches the comparator at once.
      if (duty_write) begin
         st_nxt.duty_buf = duty_write_data;
         if (!double_buffer_en) begin
            st_nxt.duty_act = duty_write_data;
         end
      end
      if (double_buffer_en && low_ovf) begin
         st_nxt.duty_act = duty_write ? duty_write_data : st_r.duty_buf;
      end

      // A software write to the flip-flop takes priority over a toggle in the same cycle.
      if (ff_write) begin
         case (ff_op)
            pwm_pkg::FF_OP_INVERT: st_nxt.ff = ~st_r.ff;
            pwm_pkg::FF_OP_SET:    st_nxt.ff = 1'b1;
            pwm_pkg::FF_OP_CLEAR:  st_nxt.ff = 1'b0;
            default:               st_nxt.ff = st_r.ff;
         endcase
      end else if (toggle_en && (low_ovf || low_match)) begin
         st_nxt.ff = ~st_r.ff;
      end

      if (high_const_write) begin
         st_nxt.high_const = high_const_write_data;
      end
      if (!high_run) begin
         st_nxt.high_cnt = pwm_pkg::CNT_RESET;
      end else if (high_tick) begin
         if (high_inc == st_r.high_const) begin
            st_nxt.high_cnt   = pwm_pkg::CNT_RESET;
            st_nxt.high_match = 1'b1;
         end else begin
            st_nxt.high_cnt = high_inc;
         end
      end

      // Outside PWM mode the pad carries the port bit; the high timer never reaches it.
      st_nxt.pin = (pin_route_timer && pwm_mode) ? st_nxt.ff : shared_port_bit;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_r            <= '0;
         st_r.duty_buf   <= pwm_pkg::DUTY_RESET;
         st_r.duty_act   <= pwm_pkg::DUTY_RESET;
         st_r.high_const <= pwm_pkg::CONST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pwm_output_pin   = st_r.pin;
   assign output_flip_flop = st_r.ff;
   assign low_count        = st_r.low_cnt;
   assign high_count       = st_r.high_cnt;
   assign duty_active      = st_r.duty_act;
   assign high_match       = st_r.high_match;
endmodule // timer_pair_pwm

// ==== verification/pwm_load.sv ====
// Load model that times the pulses arriving on the PWM output pin.
`timescale 1ns/1ps
module pwm_load (
   input  wire logic clock,
   input  wire logic pin,
   output int        period,
   output int        high_w,
   output int        rises
);
   int   cnt;
   logic last = 1'b0;
   // The load only listens, so it puts nothing back on the pin.
   always @(posedge clock) begin
      cnt++;
      if (pin && !last) begin
         period = cnt;
         cnt = 0;
         rises++;
      end
      if (!pin && last) begin
         high_w = cnt;
      end
      last = pin;
   end
endmodule // pwm_load

// ==== verification/pwm_checker_assertions.sv ====
// Concurrent checks on the ports of the PWM timer pair.
`timescale 1ns/1ps
module pwm_checker (
   input wire logic       clock,
   input wire logic       reset_n,
   input wire logic       low_run,
   input wire logic [1:0] pair_mode_field,
   input wire logic [1:0] period_select,
   input wire logic       double_buffer_en,
   input wire logic       ff_write,
   input wire logic [1:0] ff_op,
   input wire logic       toggle_en,
   input wire logic       pin_route_timer,
   input wire logic       shared_port_bit,
   input wire logic       pwm_output_pin,
   input wire logic       output_flip_flop,
   input wire logic [7:0] low_count,
   input wire logic [7:0] duty_active,
   input wire logic       high_match
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   chk_count_step: assert property ($changed(low_count) |-> low_count == 8'($past(low_count) + 8'h01) ||
      low_count == 8'h00) else $error("low counter jumped");
   chk_top_bound: assert property (period_select == pwm_pkg::PERIOD_N6 && $past(period_select) ==
      pwm_pkg::PERIOD_N6 |-> low_count < pwm_pkg::TOP_N6) else $error("counter passed short top");
   chk_wrap_toggle: assert property (low_count == 8'h00 && $past(low_count) != 8'h00 && $past(low_run) &&
      $past(toggle_en) && !$past(ff_write) && $past(pair_mode_field) == pwm_pkg::MODE_PWM
      |-> output_flip_flop != $past(output_flip_flop)) else $error("no toggle at wrap");
   chk_match_toggle: assert property (low_count == duty_active && $changed(low_count) &&
      low_count != 8'h00 && $past(toggle_en) && !$past(ff_write)
      |-> output_flip_flop != $past(output_flip_flop)) else $error("no toggle at match");
   chk_ff_steady: assert property ($stable(low_count) && !$past(ff_write) |->
      $stable(output_flip_flop)) else $error("flip-flop moved without cause");
   chk_ff_clear: assert property (ff_write && ff_op == pwm_pkg::FF_OP_CLEAR |=>
      !output_flip_flop) else $error("flip-flop not cleared");
   chk_pin_route: assert property ($past(pin_route_timer) && $past(pair_mode_field) == pwm_pkg::MODE_PWM
      |-> pwm_output_pin == output_flip_flop) else $error("pin not showing flip-flop");
   chk_pin_port: assert property ($past(pair_mode_field) != pwm_pkg::MODE_PWM |->
      pwm_output_pin == $past(shared_port_bit)) else $error("pin not showing port bit");
   chk_idle_mode: assert property ($past(pair_mode_field) != pwm_pkg::MODE_PWM |->
      low_count == 8'h00) else $error("low counter ran outside PWM mode");
   chk_buffer_hold: assert property ($past(double_buffer_en) && low_count != 8'h00 |->
      $stable(duty_active)) else $error("active duty changed mid-period");
   chk_match_pulse: assert property (high_match |=> !high_match) else $error("high match too long");
endmodule // pwm_checker
bind timer_pair_pwm pwm_checker chk (.clock, .reset_n, .low_run, .pair_mode_field, .period_select,
   .double_buffer_en, .ff_write, .ff_op, .toggle_en, .pin_route_timer, .shared_port_bit, .pwm_output_pin,
   .output_flip_flop, .low_count, .duty_active, .high_match);

// ==== verification/tb_eight_bit_pwm_timer_pair.sv ====
// Self-checking bench for the PWM timer pair.
`timescale 1ns/1ps
module tb_eight_bit_pwm_timer_pair;
   logic clock = 1'b0, reset_n = 1'b0, low_run = 1'b0, high_run = 1'b0, double_buffer_en = 1'b0;
   logic duty_write = 1'b0, high_const_write = 1'b0, ff_write = 1'b0, toggle_en = 1'b0;
   logic pin_route_timer = 1'b0, shared_port_bit = 1'b0, pwm_output_pin, output_flip_flop, high_match;
   logic [1:0] pair_mode_field = 2'h0, period_select = 2'h0, low_clock_select = 2'h0;
   logic [1:0] high_clock_select = 2'h0, ff_op = 2'h3;
   logic [7:0] duty_write_data = 8'h00, high_const_write_data = 8'h00, low_count, high_count, duty_active;
   int fails, n_checks, cyc, top, t;
   timer_pair_pwm dut (.clock, .reset_n, .low_run, .high_run, .pair_mode_field, .period_select,
      .low_clock_select, .high_clock_select, .ext_clock_pin(1'b0), .double_buffer_en, .duty_write,
      .duty_write_data, .high_const_write, .high_const_write_data, .ff_write, .ff_op, .toggle_en,
      .pin_route_timer, .shared_port_bit, .pwm_output_pin, .output_flip_flop, .low_count, .high_count,
      .duty_active, .high_match);
   pwm_load ld (.clock, .pin(pwm_output_pin), .period(), .high_w(), .rises());
   initial begin
      forever #4 clock = ~clock;
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic duty(input logic [7:0] v);
      @(negedge clock) {duty_write, duty_write_data} = {1'b1, v};
      @(negedge clock) duty_write = 1'b0;
   endtask
   task automatic ffw(input logic [1:0] op);
      @(negedge clock) {ff_write, ff_op} = {1'b1, op};
      @(negedge clock) ff_write = 1'b0;
   endtask
   task automatic wait_rises(input int k);
      t = ld.rises + k;
      while (ld.rises < t) @(posedge clock);
   endtask
   task automatic conclude;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // The ceiling allows the three long periods plus margin; a hang ends here.
   always @(posedge clock) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      {pair_mode_field, low_clock_select} = {pwm_pkg::MODE_PWM, pwm_pkg::LOW_CLK_T1};
      {toggle_en, pin_route_timer, high_run} = 3'b111;
      for (int i = 1; i < 4; i++) begin
         @(negedge clock) low_run = 1'b0;
         duty(8'h20);
         cmp(duty_active, 8'h20);
         period_select = 2'(i);
         ffw(pwm_pkg::FF_OP_CLEAR);
         @(negedge clock) low_run = 1'b1;
         wait_rises(3);
         top = (1 << (i + 5)) - 1;
         cmp(16'(ld.period), 16'(top * 4));
         cmp(16'(ld.high_w), 16'((top - 32) * 4));
      end
      @(negedge clock);
      cmp(high_count, 8'h00);
      {high_const_write, high_const_write_data, high_clock_select} = {1'b1, 8'h03, pwm_pkg::HIGH_CLK_T1};
      @(negedge clock) {high_const_write, double_buffer_en} = 2'b01;
      duty(8'h46);
      cmp(duty_active, 8'h20);
      wait (high_match === 1'b1);
      // The pulse still stands at the next falling edge, so counting starts from there.
      @(negedge clock) t = 0;
      do begin
         @(negedge clock) t++;
      end while (high_match !== 1'b1);
      cmp(16'(t), 16'h000C);
      wait_rises(3);
      cmp(duty_active, 8'h46);
      cmp(16'(ld.high_w), 16'((255 - 70) * 4));
      @(negedge clock) {pair_mode_field, shared_port_bit} = {2'h0, 1'b1};
      repeat (3) @(negedge clock);
      cmp(pwm_output_pin, 1'b1);
      cmp(low_count, 8'h00);
      conclude();
   end
endmodule // tb_eight_bit_pwm_timer_pair
